// File: testbench/iobac_host_model.sv
// Host processor model: byte accesses and page selection at the register port.
// Assumes inputs change at the falling edge and the design samples at the rising one.
`timescale 1ns/10ps
module iobac_host_model (
   input  wire logic                 clock,
   input  wire logic [7:0]           rdata_q,
   output iobac_pkg::iobac_host_req_t host_req,
   output iobac_pkg::iobac_page_t     page
);
   import iobac_pkg::*;
   initial begin
      host_req = '0;
      page     = '0;
   end
   // Between accesses address and data are inverted so stale values never look valid.
   task automatic access(input logic w, input logic [4:0] a, input logic [7:0] wd,
                         output logic [7:0] d);
      @(negedge clock);
      host_req.rd    = !w;
      host_req.wr    = w;
      host_req.addr  = a;
      host_req.wdata = wd;
      @(posedge clock);
      @(negedge clock);
      d              = rdata_q;
      host_req.rd    = 1'b0;
      host_req.wr    = 1'b0;
      host_req.addr  = ~a;
      host_req.wdata = ~wd;
   endtask
   task automatic set_page(input logic [1:0] p);
      page = p;
   endtask
endmodule // iobac_host_model

// File: testbench/iobac_regs_checker.sv
// Concurrent checks on the ports of the I/O base and auto-configuration registers.
// Bound to iobac_regs from the testbench top; single clock domain.
`timescale 1ns/10ps
module iobac_regs_checker (
   input wire logic                      clock,
   input wire logic                      rst_b,
   input wire iobac_pkg::iobac_host_req_t host_req,
   input wire iobac_pkg::iobac_page_t    page,
   input wire logic                      autostep_cmd_write,
   input wire logic                      sid_hit,
   input wire logic [7:0]                user_id_low,
   input wire logic [7:0]                sixth_id_byte,
   input wire logic                      eeprom_store_done,
   input wire logic                      irq,
   input wire logic                      irq_mode_select,
   input wire logic [7:0]                rdata_q,
   input wire logic                      rvalid_q,
   input wire logic [7:0]                first_config_q,
   input wire logic [3:0]                eeprom_store_data_q,
   input wire logic                      reload_config_q,
   input wire logic                      remote_count0_wr_q,
   input wire logic [7:0]                remote_count0_data_q,
   input wire logic                      autostep_cmd_q,
   input wire logic                      lock_status_q,
   input wire logic [4:0]                io_base_q,
   input wire logic [3:0]                irq_output_pins_q,
   input wire logic [3:0]                irq_output_oe_q
);
   import iobac_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // --------------------------------------------------------------
   // Helpers: reset settle delay and the config A read arm.
   // --------------------------------------------------------------
   logic [2:0] live_q;
   logic       arm_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) live_q <= 3'h0;
      else        live_q <= {live_q[1:0], 1'b1};
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) arm_q <= 1'b0;
      else if (host_req.rd || host_req.wr)
         arm_q <= host_req.rd && host_req.addr[3:0] == OFF_FIRST_CONFIG && !page.enable;
   end
   sequence s_cfg_write;
      host_req.wr && host_req.addr[3:0] == OFF_FIRST_CONFIG && !page.enable;
   endsequence
   sequence s_sig_read;
      host_req.rd && host_req.addr[3:0] == OFF_SIGNATURE;
   endsequence

   a_read_answer: assert property (host_req.rd |=> rvalid_q)
      else $error("read not answered");
   a_rvalid_cause: assert property (rvalid_q |-> $past(host_req.rd))
      else $error("answer without read");
   a_status_page: assert property (host_req.rd && host_req.addr[3:0] == OFF_AUTOSTEP
      && page != 2'b11 |=> rdata_q == 8'h00) else $error("status read off page");
   a_sig_mismatch: assert property (s_sig_read ##0 user_id_low != sixth_id_byte
      |=> rdata_q == 8'h00) else $error("signature read despite id mismatch");
   a_sig_clears: assert property (s_sig_read ##0 page == 2'b11 && !sid_hit
      && user_id_low == sixth_id_byte && !eeprom_store_data_q[HCF_LOCK] |=> !lock_status_q)
      else $error("lock status kept after signature read");
   a_cmd_set: assert property (autostep_cmd_write |=> autostep_cmd_q)
      else $error("command bit not set");
   a_cmd_clear: assert property (host_req.rd && !autostep_cmd_write |=> !autostep_cmd_q)
      else $error("command bit survives read");
   a_reload_cause: assert property (reload_config_q |-> $past(eeprom_store_done))
      else $error("reload without store");
   a_cfg_commit: assert property (arm_q ##0 s_cfg_write |=>
      first_config_q == $past(host_req.wdata) && !remote_count0_wr_q)
      else $error("armed write lost");
   a_cfg_redirect: assert property (!arm_q ##0 s_cfg_write |=> remote_count0_wr_q
      && remote_count0_data_q == $past(host_req.wdata) && $stable(first_config_q))
      else $error("unarmed write not redirected");
   a_locked_step: assert property (autostep_cmd_write && lock_status_q
      |=> $stable(io_base_q)[*2]) else $error("base moved while locked");
   a_irq_direct: assert property (live_q[2] && !$past(irq_mode_select) |->
      irq_output_oe_q == 4'h1 << $past(first_config_q[4:3])
      && irq_output_pins_q == {4{$past(irq)}}) else $error("direct pin drive wrong");
   a_irq_alt: assert property (live_q[2] && $past(irq_mode_select) |->
      irq_output_oe_q == 4'hf && irq_output_pins_q == {$past(irq), $past(first_config_q[5:3])})
      else $error("alternative pin drive wrong");
endmodule // iobac_regs_checker

// File: testbench/tb_iobac_regs.sv
// Self-checking testbench of the I/O base and auto-configuration registers.
// Uses the host model for register accesses and binds the port checker.
`timescale 1ns/10ps
module tb_iobac_regs;
   import iobac_pkg::*;
   logic clock = 1'b0, rst_b = 1'b0, hidden_config_enable, autostep_cmd_write, sid_hit;
   logic eeprom_load, eeprom_store_done, irq, irq_mode_select, rvalid_q, reload_config_q;
   logic remote_count0_wr_q, autostep_cmd_q, lock_status_q;
   logic [7:0] user_id_low, sixth_id_byte, rdata_q, first_config_q, remote_count0_data_q;
   logic [7:0] d, v;
   logic [3:0] eeprom_load_data, eeprom_store_data_q, irq_output_pins_q, irq_output_oe_q;
   logic [4:0] io_base_q;
   iobac_host_req_t host_req;
   iobac_page_t     page;
   int n_fail = 0, total_checks = 0;

   always #20 clock = ~clock;
   iobac_host_model u_iobac_host_model (.clock, .rdata_q, .host_req, .page);
   iobac_regs u_iobac_regs (.clock, .rst_b, .host_req, .page, .hidden_config_enable,
      .autostep_cmd_write, .sid_hit, .user_id_low, .sixth_id_byte, .eeprom_load,
      .eeprom_load_data, .eeprom_store_done, .irq, .irq_mode_select, .rdata_q, .rvalid_q,
      .first_config_q, .eeprom_store_data_q, .reload_config_q, .remote_count0_wr_q,
      .remote_count0_data_q, .autostep_cmd_q, .lock_status_q, .io_base_q,
      .irq_output_pins_q, .irq_output_oe_q);

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] r;
      u_iobac_host_model.access(1'b0, a, 8'h00, r);
      check(r, e);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] x);
      logic [7:0] r;
      u_iobac_host_model.access(1'b1, a, x, r);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
   endtask
   task automatic do_reset();
      @(negedge clock);
      rst_b = 1'b0;
      repeat (3) @(negedge clock);
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #(40 * 5000);
      n_fail++;
      finish_test();
   end

   initial begin
      {hidden_config_enable, autostep_cmd_write, sid_hit, eeprom_load} = 4'h0;
      {eeprom_store_done, irq, irq_mode_select} = 3'h0;
      user_id_low = 8'h3c;
      sixth_id_byte = 8'h3c;
      eeprom_load_data = 4'h0;
      do_reset();
      u_iobac_host_model.set_page(2'b11);
      hidden_config_enable = 1'b1;
      rd_chk(5'h09, 8'h00);
      rd_chk(5'h1e, ASR_RESET);
      wr(5'h09, 8'hf0);
      rd_chk(5'h09, 8'h00);
      for (int i = 0; i < 8; i++) begin
         pulse(autostep_cmd_write);
         check(8'(autostep_cmd_q), 8'h01);
         rd_chk(5'h0e, (i == 6) ? STEP_LAST_SHORT : STEP_TABLE[i % 7]);
         check(8'(autostep_cmd_q), 8'h00);
      end
      do_reset();
      wr(5'h09, 8'h01);
      for (int i = 0; i < 15; i++) begin
         pulse(autostep_cmd_write);
         rd_chk(5'h0e, STEP_TABLE[i]);
         rd_chk(5'h09, {6'h00, i[3], 1'b1});
         check(8'(io_base_q), {3'h0, 1'b1, i[3:0]});
      end
      hidden_config_enable = 1'b0;
      repeat (2) @(negedge clock);
      check(8'(io_base_q), 8'h16);
      hidden_config_enable = 1'b1;
      wr(5'h09, 8'h09);
      pulse(autostep_cmd_write);
      rd_chk(5'h0e, STEP_TABLE[14]);
      rd_chk(5'h08, 8'h00);
      wr(5'h09, 8'h01);
      rd_chk(5'h08, SIGNATURE_VALUE);
      rd_chk(5'h18, SIGNATURE_VALUE);
      sixth_id_byte = 8'h3d;
      rd_chk(5'h08, 8'h00);
      sixth_id_byte = 8'h3c;
      u_iobac_host_model.set_page(2'b10);
      rd_chk(5'h08, 8'h00);
      rd_chk(5'h0e, 8'h00);
      u_iobac_host_model.set_page(2'b11);
      pulse(sid_hit);
      check(8'(lock_status_q), 8'h01);
      pulse(autostep_cmd_write);
      rd_chk(5'h0e, STEP_TABLE[14]);
      rd_chk(5'h08, SIGNATURE_VALUE);
      check(8'(lock_status_q), 8'h00);
      wr(5'h09, 8'h05);
      @(negedge clock);
      check(8'(eeprom_store_data_q), 8'h05);
      pulse(eeprom_store_done);
      check(8'(reload_config_q), 8'h01);
      eeprom_load_data = 4'hb;
      pulse(eeprom_load);
      rd_chk(5'h09, 8'h0b);
      wr(5'h09, 8'h00);
      pulse(eeprom_store_done);
      check(8'(reload_config_q), 8'h00);
      u_iobac_host_model.set_page(2'b00);
      d = first_config_q;
      u_iobac_host_model.access(1'b0, 5'h0a, 8'h00, v);
      rd_chk(5'h0e, 8'h00);
      wr(5'h0a, 8'h2d);
      check(8'(remote_count0_wr_q), 8'h01);
      check(remote_count0_data_q, 8'h2d);
      check(first_config_q, d);
      for (int j = 0; j < 4; j++) begin
         v = {2'b00, ~j[0], j[1:0], 3'b101};
         u_iobac_host_model.access(1'b0, 5'h0a, 8'h00, d);
         wr(5'h0a, v);
         check(first_config_q, v);
         check(8'(remote_count0_wr_q), 8'h00);
         irq = j[0];
         irq_mode_select = 1'b0;
         repeat (2) @(negedge clock);
         check(8'(io_base_q), 8'h05);
         check(8'(irq_output_oe_q), 8'(4'h1 << j[1:0]));
         check(8'(irq_output_pins_q), 8'({4{j[0]}}));
         irq_mode_select = 1'b1;
         repeat (2) @(negedge clock);
         check(8'(irq_output_oe_q), 8'h0f);
         check(8'(irq_output_pins_q), {4'h0, j[0], ~j[0], j[1:0]});
      end
      finish_test();
   end
endmodule // tb_iobac_regs

bind iobac_regs iobac_regs_checker u_iobac_regs_checker (.clock, .rst_b, .host_req, .page,
   .autostep_cmd_write, .sid_hit, .user_id_low, .sixth_id_byte, .eeprom_store_done, .irq,
   .irq_mode_select, .rdata_q, .rvalid_q, .first_config_q, .eeprom_store_data_q,
   .reload_config_q, .remote_count0_wr_q, .remote_count0_data_q, .autostep_cmd_q,
   .lock_status_q, .io_base_q, .irq_output_pins_q, .irq_output_oe_q);

// File: verilog/iobac_autostep.sv
// Auto-step sequencer: steps through the auto-configuration status values.
// Assumes step requests are one-cycle pulses already qualified by the lock.
`timescale 1ns/10ps
module iobac_autostep (
   input  wire logic       clock,
   input  wire logic       rst_sync_b,
   input  wire logic       step,
   input  wire logic       fifteen,
   output logic [7:0]      status_q,
   output logic [3:0]      index_q
);
   import iobac_pkg::*;

   logic       started_q;
   logic [3:0] next_idx;
   logic [3:0] limit;

   always_comb begin
      limit    = fifteen ? STEPS_LONG : STEPS_SHORT;
      next_idx = (!started_q || index_q == limit - 4'd1) ? 4'd0 : index_q + 4'd1;
   end

   // The first step always lands on entry zero.
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         started_q <= 1'b0;
         index_q   <= 4'd0;
         status_q  <= ASR_RESET;
      end else if (step) begin
         started_q <= 1'b1;
         index_q   <= next_idx;
         if (!fifteen && next_idx == STEPS_SHORT - 4'd1) begin
            status_q <= STEP_LAST_SHORT;
         end else begin
            status_q <= STEP_TABLE[next_idx];
         end
      end
   end

endmodule // iobac_autostep

// File: verilog/iobac_irq_pins.sv
// Interrupt pin driver for the four interrupt outputs.
// Assumes irq is a level from the controller core, synchronous to clock.
`timescale 1ns/10ps
module iobac_irq_pins (
   input  wire logic       clock,
   input  wire logic       rst_sync_b,
   input  wire logic       irq,
   input  wire logic       alt_mode,
   input  wire logic [2:0] select,
   output logic [3:0]      pin_out_q,
   output logic [3:0]      pin_oe_q
);
   import iobac_pkg::*;

   iobac_irq_mode_t mode;

   always_comb begin
      mode = alt_mode ? IRQ_ST_ALT : IRQ_ST_DIRECT;
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pin_out_q <= 4'h0;
         pin_oe_q  <= 4'h0;
      end else begin
         unique case (mode)
            IRQ_ST_DIRECT: begin
               // Only the chosen pin is driven; the top select bit is ignored.
               pin_out_q <= {4{irq}};
               pin_oe_q  <= 4'b0001 << select[1:0];
            end
            IRQ_ST_ALT: begin
               // Pin 3 carries the interrupt, pins 0 to 2 mirror the field.
               pin_out_q <= {irq, select};
               pin_oe_q  <= 4'hf;
            end
         endcase
      end
   end

endmodule // iobac_irq_pins

// File: verilog/iobac_pkg.sv
// Constants, types and the auto-step table of the I/O base and auto-configuration register set.
// Assumes a single 25 MHz clock domain and host accesses already synchronous to it.
package iobac_pkg;

   // ------------------------------------------------------------------
   // Register offsets within the window (low nibble; bit 4 is not decoded)
   // ------------------------------------------------------------------
   localparam logic [3:0] OFF_SIGNATURE     = 4'h8;
   localparam logic [3:0] OFF_HIDDEN_CONFIG = 4'h9;
   localparam logic [3:0] OFF_FIRST_CONFIG  = 4'ha;
   localparam logic [3:0] OFF_AUTOSTEP      = 4'he;

   // ------------------------------------------------------------------
   // Hidden configuration register fields
   // ------------------------------------------------------------------
   localparam int HCF_BASE_COUNT = 0;
   localparam int HCF_BANK       = 1;
   localparam int HCF_RELOAD     = 2;
   localparam int HCF_LOCK       = 3;
   localparam logic [3:0] HCF_RESET = 4'h0;

   // ------------------------------------------------------------------
   // First configuration register fields
   // ------------------------------------------------------------------
   localparam int CA_BASE_LSB = 0;
   localparam int CA_IRQ_LSB  = 3;
   localparam logic [7:0] CA_RESET = 8'h00;

   // Arbitrary signature code; not tied to any maker.
   localparam logic [7:0] SIGNATURE_VALUE = 8'h5a;

   localparam logic [7:0] ASR_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Auto-step sequence
   // ------------------------------------------------------------------
   localparam logic [3:0] STEPS_SHORT = 4'd7;
   localparam logic [3:0] STEPS_LONG  = 4'd15;
   localparam logic [7:0] STEP_TABLE [15] = '{
      8'h18, 8'h22, 8'h34, 8'h46, 8'h59, 8'h6a, 8'h7b, 8'h8c,
      8'h9d, 8'hae, 8'hbf, 8'hc0, 8'hd1, 8'he5, 8'h07};
   localparam logic [7:0] STEP_LAST_SHORT = 8'h0b;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } iobac_host_req_t;

   typedef struct packed {
      logic       enable;
      logic       choice;
   } iobac_page_t;

   typedef enum logic [1:0] {
      IRQ_ST_DIRECT = 2'b01,
      IRQ_ST_ALT    = 2'b10
   } iobac_irq_mode_t;

endpackage

// File: verilog/iobac_regs.sv
// Top of the I/O base and auto-configuration register set.
// Assumes host strobes are one-cycle pulses synchronous to clock and that the
// hidden command register, page selects and EEPROM engine live outside.
`timescale 1ns/10ps

module iobac_regs (
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   input  wire iobac_pkg::iobac_host_req_t host_req,
   input  wire iobac_pkg::iobac_page_t    page,
   input  wire logic                      hidden_config_enable,
   input  wire logic                      autostep_cmd_write,
   input  wire logic                      sid_hit,
   input  wire logic [7:0]                user_id_low,
   input  wire logic [7:0]                sixth_id_byte,
   input  wire logic                      eeprom_load,
   input  wire logic [3:0]                eeprom_load_data,
   input  wire logic                      eeprom_store_done,
   input  wire logic                      irq,
   input  wire logic                      irq_mode_select,
   output logic [7:0]                     rdata_q,
   output logic                           rvalid_q,
   output logic [7:0]                     first_config_q,
   output logic [3:0]                     eeprom_store_data_q,
   output logic                           reload_config_q,
   output logic                           remote_count0_wr_q,
   output logic [7:0]                     remote_count0_data_q,
   output logic                           autostep_cmd_q,
   output logic                           lock_status_q,
   output logic [4:0]                     io_base_q,
   output logic [3:0]                     irq_output_pins_q,
   output logic [3:0]                     irq_output_oe_q
);
   import iobac_pkg::*;

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   logic       new_page1;
   logic       page0;
   logic       hit_sig;
   logic       hit_hcf;
   logic       hit_ca;
   logic       hit_asr;
   logic       sig_readable;
   logic       step_req;
   logic       step_go;
   logic [3:0] hcf_q;
   logic       bank_eff;
   logic [7:0] autostep_status;
   logic [3:0] step_idx;
   logic       step_done_q;

   always_comb begin
      new_page1    = page.enable & page.choice;
      page0        = ~page.enable;
      hit_sig      = new_page1 && host_req.addr[3:0] == OFF_SIGNATURE;
      hit_hcf      = new_page1 && host_req.addr[3:0] == OFF_HIDDEN_CONFIG;
      hit_ca       = page0 && host_req.addr[3:0] == OFF_FIRST_CONFIG;
      hit_asr      = new_page1 && host_req.addr[3:0] == OFF_AUTOSTEP;
      sig_readable = hit_sig && !hcf_q[HCF_LOCK]
                     && user_id_low == sixth_id_byte;
      bank_eff     = hcf_q[HCF_BANK] & hcf_q[HCF_BASE_COUNT]
                     & hidden_config_enable;
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= host_req.rd;
         if (host_req.rd) begin
            if (sig_readable) begin
               rdata_q <= SIGNATURE_VALUE;
            end else if (hit_hcf) begin
               rdata_q <= {4'h0, hcf_q};
            end else if (hit_ca) begin
               rdata_q <= first_config_q;
            end else if (hit_asr) begin
               rdata_q <= autostep_status;
            end else begin
               rdata_q <= 8'h00;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Hidden configuration register
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         hcf_q <= HCF_RESET;
      end else if (host_req.wr && hit_hcf) begin
         hcf_q <= host_req.wdata[3:0];
      end else if (eeprom_load) begin
         hcf_q <= eeprom_load_data;
      end else if (step_done_q && hcf_q[HCF_BASE_COUNT]) begin
         hcf_q[HCF_BANK] <= step_idx[3];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         eeprom_store_data_q <= HCF_RESET;
         reload_config_q     <= 1'b0;
      end else begin
         eeprom_store_data_q <= hcf_q;
         reload_config_q     <= eeprom_store_done & hcf_q[HCF_RELOAD];
      end
   end

   // ------------------------------------------------------------------
   // Lock status and auto-step command
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         lock_status_q <= 1'b0;
      end else if (sid_hit) begin
         lock_status_q <= 1'b1;
      end else if (host_req.rd && sig_readable) begin
         lock_status_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         autostep_cmd_q <= 1'b0;
      end else if (autostep_cmd_write) begin
         autostep_cmd_q <= 1'b1;
      end else if (host_req.rd) begin
         autostep_cmd_q <= 1'b0;
      end
   end

   always_comb begin
      step_req = autostep_cmd_write;
      step_go  = step_req && !hcf_q[HCF_LOCK] && !lock_status_q;
   end

   // The sequencer index moves on the step edge, so the base fields are loaded one
   // edge later from the new index rather than from the one being left.
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         step_done_q <= 1'b0;
      end else begin
         step_done_q <= step_go;
      end
   end

   iobac_autostep u_autostep (
      .clock      (clock),
      .rst_sync_b (rst_sync_b),
      .step       (step_go),
      .fifteen    (hcf_q[HCF_BASE_COUNT]),
      .status_q   (autostep_status),
      .index_q    (step_idx)
   );

   // ------------------------------------------------------------------
   // First configuration register and its read-then-write gate
   // ------------------------------------------------------------------
   logic ca_armed_q;

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ca_armed_q <= 1'b0;
      end else if (host_req.rd || host_req.wr) begin
         ca_armed_q <= host_req.rd && hit_ca;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         first_config_q <= CA_RESET;
      end else if (host_req.wr && hit_ca && ca_armed_q) begin
         first_config_q <= host_req.wdata;
      end else if (step_done_q) begin
         first_config_q[CA_BASE_LSB +: 3] <= step_idx[2:0];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         remote_count0_wr_q   <= 1'b0;
         remote_count0_data_q <= 8'h00;
      end else begin
         remote_count0_wr_q <= host_req.wr && hit_ca && !ca_armed_q;
         if (host_req.wr && hit_ca && !ca_armed_q) begin
            remote_count0_data_q <= host_req.wdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // I/O base selection
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         io_base_q <= 5'h00;
      end else if (page.enable) begin
         io_base_q <= {page.choice, bank_eff,
                       first_config_q[CA_BASE_LSB +: 3]};
      end else begin
         io_base_q <= {2'b00, first_config_q[CA_BASE_LSB +: 3]};
      end
   end

   // ------------------------------------------------------------------
   // Interrupt pins
   // ------------------------------------------------------------------
   iobac_irq_pins u_irq_pins (
      .clock      (clock),
      .rst_sync_b (rst_sync_b),
      .irq        (irq),
      .alt_mode   (irq_mode_select),
      .select     (first_config_q[CA_IRQ_LSB +: 3]),
      .pin_out_q  (irq_output_pins_q),
      .pin_oe_q   (irq_output_oe_q)
   );

endmodule // iobac_regs
